// ==== dpr_port_host.sv ====
// controller that drives one port of the asynchronous dual-port memory
`timescale 1ns/100ps
module dpr_port_host
  import dpr_host_pkg::*;
(
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic req,
  input wire logic [1:0] op,
  input wire logic [ADDR_W-1:0] req_addr,
  input wire logic [DATA_W-1:0] wdata,
  input wire logic [1:0] lane_en,
  input wire logic flow_wait,
  output logic ready,
  output logic done,
  output logic [DATA_W-1:0] rdata,
  output logic alert,
  output logic busy_seen,
  output logic port_select_n,
  output logic token_latch_select_n,
  output logic write_strobe_n,
  output logic drive_enable_n,
  output logic high_byte_lane_n,
  output logic low_byte_lane_n,
  output logic [ADDR_W-1:0] addr,
  output logic [DATA_W-1:0] data_out,
  output logic data_oe,
  input wire logic [DATA_W-1:0] data_in,
  input wire logic busy_n,
  input wire logic alert_n
);
  typedef enum logic [2:0] {ST_IDLE, ST_SETUP, ST_PULSE, ST_READ, ST_RECOVER} state_t;

  state_t state_q;
  op_t op_q;
  logic flow_q;
  logic tmr_load;
  logic [CNT_W-1:0] tmr_val;
  logic tmr_last;
  logic is_sem;
  logic is_wr;

  assign is_sem = (op_q == OP_SEM_RD) || (op_q == OP_SEM_WR);
  assign is_wr = (op_q == OP_MEM_WR) || (op_q == OP_SEM_WR);

  dpr_phase_timer u_timer (
    .clk(clk),
    .sys_rst(sys_rst),
    .load(tmr_load),
    .load_val(tmr_val),
    .last(tmr_last)
  );

  // phase length chosen on each phase entry
  always_comb begin
    tmr_load = 1'b0;
    tmr_val = SETUP_CYC;
    case (state_q)
      ST_IDLE: begin
        tmr_load = req;
        tmr_val = SETUP_CYC;
      end
      ST_SETUP: begin
        tmr_load = tmr_last;
        tmr_val = is_wr ? WRITE_CYC : (flow_q ? READ_FLOW_CYC : ACCESS_CYC);
      end
      ST_PULSE: begin
        tmr_load = tmr_last;
        tmr_val = RECOVER_CYC;
      end
      ST_READ: begin
        tmr_load = tmr_last;
        tmr_val = busy_n ? RECOVER_CYC : ACCESS_CYC;
      end
      default: begin
        tmr_load = 1'b0;
        tmr_val = SETUP_CYC;
      end
    endcase
  end

  // sequencing of one access
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      state_q <= ST_IDLE;
    end else begin
      case (state_q)
        ST_IDLE: begin
          if (req) begin
            state_q <= ST_SETUP;
          end
        end
        ST_SETUP: begin
          if (tmr_last) begin
            state_q <= is_wr ? ST_PULSE : ST_READ;
          end
        end
        ST_PULSE: begin
          if (tmr_last) begin
            state_q <= ST_RECOVER;
          end
        end
        ST_READ: begin
          if (tmr_last && busy_n) begin
            state_q <= ST_RECOVER;
          end
        end
        ST_RECOVER: begin
          if (tmr_last) begin
            state_q <= ST_IDLE;
          end
        end
        default: begin
          state_q <= ST_IDLE;
        end
      endcase
    end
  end

  // request capture; address only moves while idle with the strobe high
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      op_q <= OP_MEM_RD;
      flow_q <= 1'b0;
      addr <= '0;
      data_out <= '0;
      high_byte_lane_n <= 1'b1;
      low_byte_lane_n <= 1'b1;
    end else if (state_q == ST_IDLE && req) begin
      op_q <= op_t'(op);
      flow_q <= flow_wait;
      if (op[1]) begin
        addr <= req_addr & SEM_ADDR_MASK;
        data_out <= {{(DATA_W-1){1'b0}}, wdata[SEM_FLAG_BIT]};
        high_byte_lane_n <= 1'b1;
        low_byte_lane_n <= 1'b1;
      end else begin
        addr <= req_addr;
        data_out <= wdata;
        high_byte_lane_n <= ~lane_en[1];
        low_byte_lane_n <= ~lane_en[0];
      end
    end
  end

  // selects: asserted from setup to end of access, never both at once
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      port_select_n <= 1'b1;
      token_latch_select_n <= 1'b1;
    end else if (state_q == ST_IDLE && req) begin
      port_select_n <= op[1];
      token_latch_select_n <= ~op[1];
    end else if ((state_q == ST_PULSE && tmr_last) || (state_q == ST_READ && tmr_last && busy_n)) begin
      port_select_n <= 1'b1;
      token_latch_select_n <= 1'b1;
    end
  end

  // strobe and data drive; outputs of the device stay off during writes
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      write_strobe_n <= 1'b1;
      data_oe <= 1'b0;
    end else if (state_q == ST_SETUP && tmr_last && is_wr) begin
      write_strobe_n <= 1'b0;
      data_oe <= 1'b1;
    end else if (state_q == ST_PULSE && tmr_last) begin
      write_strobe_n <= 1'b1;
      data_oe <= 1'b0;
    end
  end

  // drive enable only for reads
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      drive_enable_n <= 1'b1;
    end else if (state_q == ST_SETUP && tmr_last && !is_wr) begin
      drive_enable_n <= 1'b0;
    end else if (state_q == ST_READ && tmr_last && busy_n) begin
      drive_enable_n <= 1'b1;
    end
  end

  // read capture and handshake
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      rdata <= '0;
      busy_seen <= 1'b0;
    end else if (state_q == ST_IDLE && req) begin
      busy_seen <= 1'b0;
    end else if (state_q == ST_READ && tmr_last) begin
      if (!busy_n) begin
        busy_seen <= 1'b1;
      end else if (is_sem) begin
        rdata <= {{(DATA_W-1){1'b0}}, data_in[SEM_FLAG_BIT]};
      end else begin
        rdata <= data_in;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      ready <= 1'b0;
      done <= 1'b0;
      alert <= 1'b0;
    end else begin
      ready <= (state_q == ST_IDLE && !req) || (state_q == ST_RECOVER && tmr_last);
      done <= (state_q == ST_RECOVER && tmr_last);
      alert <= ~alert_n;
    end
  end

  a_addr_still: assert property (@(posedge clk) disable iff (sys_rst)
    !write_strobe_n |-> $stable(addr)) else $error("address moved during write");
  a_one_select: assert property (@(posedge clk) disable iff (sys_rst)
    !(~port_select_n && ~token_latch_select_n)) else $error("both selects low");
  a_select_hold: assert property (@(posedge clk) disable iff (sys_rst)
    !write_strobe_n |-> $stable(port_select_n) && $stable(token_latch_select_n) && $stable(low_byte_lane_n))
    else $error("select changed during write");
  a_data_setup: assert property (@(posedge clk) disable iff (sys_rst)
    $rose(write_strobe_n) |-> $past(data_oe, 1) && $past(data_oe, 2) && $past(data_oe, 3))
    else $error("data not set up before strobe rise");
  a_write_width: assert property (@(posedge clk) disable iff (sys_rst)
    $fell(write_strobe_n) |-> (!write_strobe_n && drive_enable_n)[*3]) else $error("write pulse too short");
  a_flow_wait: assert property (@(posedge clk) disable iff (sys_rst)
    $fell(drive_enable_n) && flow_q |-> (!drive_enable_n)[*6]) else $error("flowthrough wait cut short");
  a_read_sel: assert property (@(posedge clk) disable iff (sys_rst)
    !drive_enable_n |-> (!port_select_n || !token_latch_select_n) && write_strobe_n)
    else $error("read without select");
  a_token_gap: assert property (@(posedge clk) disable iff (sys_rst)
    $rose(token_latch_select_n) |-> token_latch_select_n[*2]) else $error("token select gap too short");
  a_sem_bit: assert property (@(posedge clk) disable iff (sys_rst)
    data_oe && !token_latch_select_n |-> data_out[DATA_W-1:1] == '0) else $error("semaphore write uses upper bits");

  c_mem_write: cover property (@(posedge clk) disable iff (sys_rst) $rose(write_strobe_n) && !port_select_n);
  c_sem_read: cover property (@(posedge clk) disable iff (sys_rst) $rose(drive_enable_n) && is_sem);
  c_busy_retry: cover property (@(posedge clk) disable iff (sys_rst) state_q == ST_READ && tmr_last && !busy_n);
endmodule // dpr_port_host

// ==== dpr_host_pkg.sv ====
// constants, op codes and timing counts for the dual-port memory port controller
// How it works
// - memory access: port select low, lane low, token select high; held through write
// - controller keeps the write strobe high whenever the address changes
// - write ends on strobe rise; data stable for set-up time before it
// - reading a location being written waits the flowthrough delay
// - memory read asserts both drive enable and port select
// - semaphore read asserts token select and drive enable instead
// - after semaphore write, deselect for the update pulse before reading back
// - write with drive enable low stretches pulse by turn-off plus set-up
// - alert is left unconnected to interrupts when mailboxes are unused
package dpr_host_pkg;
  localparam int CLK_PERIOD_NS = 8;
  localparam int ADDR_W = 13;
  localparam int DATA_W = 16;
  localparam int CNT_W = 4;
  localparam logic [ADDR_W-1:0] MBOX_RIGHT_ADDR = 13'h1fff;
  localparam logic [ADDR_W-1:0] MBOX_LEFT_ADDR = 13'h1ffe;
  localparam logic [ADDR_W-1:0] SEM_ADDR_MASK = 13'h0007;
  localparam int SEM_FLAG_BIT = 0;

  // least times, printed figures in ns
  localparam int ADDR_SETUP_NS = 12;
  localparam int WRITE_PULSE_NS = 12;
  localparam int OUT_OFF_NS = 10;
  localparam int DATA_SETUP_NS = 10;
  localparam int ACCESS_NS = 15;
  localparam int FLOWTHROUGH_DELAY_NS = 25;
  localparam int TOKEN_UPDATE_PULSE_NS = 10;

  function automatic int ceil_cyc(input int ns);
    int c;
    c = (ns + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    ceil_cyc = (c < 1) ? 1 : c;
  endfunction

  function automatic int max_int(input int a, input int b);
    max_int = (a > b) ? a : b;
  endfunction

  localparam int SETUP_CYC_I = ceil_cyc(ADDR_SETUP_NS - WRITE_PULSE_NS);
  localparam int WRITE_CYC_I = max_int(ceil_cyc(WRITE_PULSE_NS), ceil_cyc(OUT_OFF_NS + DATA_SETUP_NS));
  localparam int ACCESS_CYC_I = ceil_cyc(ACCESS_NS);
  localparam int FLOW_CYC_I = ceil_cyc(FLOWTHROUGH_DELAY_NS);
  localparam int RECOVER_CYC_I = ceil_cyc(TOKEN_UPDATE_PULSE_NS);
  localparam logic [CNT_W-1:0] SETUP_CYC = CNT_W'(SETUP_CYC_I);
  localparam logic [CNT_W-1:0] WRITE_CYC = CNT_W'(WRITE_CYC_I);
  localparam logic [CNT_W-1:0] ACCESS_CYC = CNT_W'(ACCESS_CYC_I);
  localparam logic [CNT_W-1:0] READ_FLOW_CYC = CNT_W'(ACCESS_CYC_I + FLOW_CYC_I);
  localparam logic [CNT_W-1:0] RECOVER_CYC = CNT_W'(RECOVER_CYC_I);

  typedef enum logic [1:0] {
    OP_MEM_RD = 2'h0,
    OP_MEM_WR = 2'h1,
    OP_SEM_RD = 2'h2,
    OP_SEM_WR = 2'h3
  } op_t;
endpackage

// ==== dpr_phase_timer.sv ====
// down counter that times each phase of a port access
`timescale 1ns/100ps
module dpr_phase_timer
  import dpr_host_pkg::*;
(
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic load,
  input wire logic [CNT_W-1:0] load_val,
  output logic last
);
  logic [CNT_W-1:0] cnt_q;

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      cnt_q <= '0;
    end else if (load) begin
      cnt_q <= load_val;
    end else if (cnt_q != '0) begin
      cnt_q <= cnt_q - 1'b1;
    end
  end

  // high in the final cycle of a loaded phase
  assign last = (cnt_q == 4'h1);
endmodule // dpr_phase_timer

// ==== dpr_dev_model.sv ====
// behavioural model of one port of the dual-port memory device
`timescale 1ns/100ps
module dpr_dev_model
  import dpr_host_pkg::*;
(
  input wire logic port_select_n,
  input wire logic token_latch_select_n,
  input wire logic write_strobe_n,
  input wire logic drive_enable_n,
  input wire logic high_byte_lane_n,
  input wire logic low_byte_lane_n,
  input wire logic [ADDR_W-1:0] addr,
  input wire logic [DATA_W-1:0] data_out,
  input wire logic data_oe,
  input wire logic busy_n,
  input wire logic peer_mbox_wr,
  output logic [DATA_W-1:0] data_in,
  output logic alert_n
);
  logic [DATA_W-1:0] mem [0:(1<<ADDR_W)-1];
  logic [7:0] flag = 8'hff;
  logic [DATA_W-1:0] val;
  logic clr;
  logic drv;
  // writes land only while the controller drives the data pins
  always @(write_strobe_n, port_select_n, token_latch_select_n, addr, data_out, data_oe,
           high_byte_lane_n, low_byte_lane_n) begin
    if (!write_strobe_n && data_oe && !port_select_n) begin
      if (!high_byte_lane_n) mem[addr][15:8] = data_out[15:8];
      if (!low_byte_lane_n) mem[addr][7:0] = data_out[7:0];
    end
    if (!write_strobe_n && data_oe && !token_latch_select_n) begin
      flag[addr[2:0]] = data_out[SEM_FLAG_BIT];
    end
  end
  assign val = !token_latch_select_n ? {DATA_W{flag[addr[2:0]]}} : mem[addr];
  // released bus shows the inverse so stale data cannot pass; outputs stay off while the strobe is low
  assign drv = !drive_enable_n && (!port_select_n || !token_latch_select_n);
  assign data_in = (drv && write_strobe_n) ? val : ~val;
  assign clr = !port_select_n && !drive_enable_n && addr == MBOX_LEFT_ADDR && busy_n;
  initial alert_n = 1'b1;
  always @(posedge peer_mbox_wr or posedge clr) alert_n <= clr;
endmodule // dpr_dev_model

// ==== tb.sv ====
// self-checking bench for the port controller against the device model
`timescale 1ns/100ps
module tb;
  import dpr_host_pkg::*;
  logic clk = 1'b0, sys_rst = 1'b1, req = 1'b0, flow_wait = 1'b0, busy_n = 1'b1, peer_mbox_wr = 1'b0, fw;
  logic [1:0] op = 2'h0, lane_en = 2'h3, l;
  logic [ADDR_W-1:0] req_addr = 13'h0, prev_addr = 13'h0, addr, a;
  logic [DATA_W-1:0] wdata = 16'h0, rdata, data_out, data_in, d;
  logic ready, done, alert, busy_seen, port_select_n, token_latch_select_n, write_strobe_n, drive_enable_n;
  logic high_byte_lane_n, low_byte_lane_n, data_oe, alert_n;
  logic [DATA_W-1:0] shadow [logic [ADDR_W-1:0]];
  int n_mismatch = 0, checks_done = 0, cycles = 0, seed = 78756;
  dpr_port_host i_dpr_port_host (
    .clk(clk),
    .sys_rst(sys_rst),
    .req(req),
    .op(op),
    .req_addr(req_addr),
    .wdata(wdata),
    .lane_en(lane_en),
    .flow_wait(flow_wait),
    .ready(ready),
    .done(done),
    .rdata(rdata),
    .alert(alert),
    .busy_seen(busy_seen),
    .port_select_n(port_select_n),
    .token_latch_select_n(token_latch_select_n),
    .write_strobe_n(write_strobe_n),
    .drive_enable_n(drive_enable_n),
    .high_byte_lane_n(high_byte_lane_n),
    .low_byte_lane_n(low_byte_lane_n),
    .addr(addr),
    .data_out(data_out),
    .data_oe(data_oe),
    .data_in(data_in),
    .busy_n(busy_n),
    .alert_n(alert_n)
  );
  dpr_dev_model i_dpr_dev_model (
    .port_select_n(port_select_n),
    .token_latch_select_n(token_latch_select_n),
    .write_strobe_n(write_strobe_n),
    .drive_enable_n(drive_enable_n),
    .high_byte_lane_n(high_byte_lane_n),
    .low_byte_lane_n(low_byte_lane_n),
    .addr(addr),
    .data_out(data_out),
    .data_oe(data_oe),
    .busy_n(busy_n),
    .peer_mbox_wr(peer_mbox_wr),
    .data_in(data_in),
    .alert_n(alert_n)
  );
  initial forever #4 clk = ~clk;
  task automatic check(input string what, input logic [DATA_W-1:0] seen, input logic [DATA_W-1:0] exp);
    checks_done++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("mismatch %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", checks_done, n_mismatch);
    if (n_mismatch == 0 && checks_done > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  function automatic logic [DATA_W-1:0] merge(input logic [DATA_W-1:0] o, input logic [DATA_W-1:0] w,
                                              input logic [1:0] ln);
    merge = {ln[1] ? w[15:8] : o[15:8], ln[0] ? w[7:0] : o[7:0]};
  endfunction
  task automatic xfer(input logic [1:0] o, input logic [ADDR_W-1:0] ad, input logic [DATA_W-1:0] wd,
                      input logic [1:0] ln, input logic f, input logic [DATA_W-1:0] exp_cyc,
                      input logic [DATA_W-1:0] exp);
    int n;
    while (ready !== 1'b1) @(negedge clk);
    op = o;
    req_addr = ad;
    wdata = wd;
    lane_en = ln;
    flow_wait = f;
    req = 1'b1;
    @(negedge clk);
    req = 1'b0;
    n = 1;
    while (done !== 1'b1 && n < 40) begin
      @(negedge clk);
      n++;
    end
    check("cycles", 16'(n), exp_cyc);
    if (!o[0]) check("rdata", rdata, exp);
  endtask
  always @(posedge clk) begin
    cycles++;
    if (cycles > 20000) begin
      n_mismatch++;
      tally_and_finish();
    end
  end
  // pin checks at the falling edge, where the controller outputs have settled
  always @(negedge clk) begin
    if (!sys_rst) begin
      if (addr !== prev_addr) check("strobe at addr change", 16'(write_strobe_n), 16'h1);
      if (!token_latch_select_n) check("token addr", 16'(addr[12:3]), 16'h0);
      if (!write_strobe_n) check("select in write", 16'(port_select_n & token_latch_select_n), 16'h0);
    end
    prev_addr <= addr;
  end
  initial begin
    repeat (12) @(negedge clk);
    sys_rst = 1'b0;
    repeat (12) begin
      a = 13'($random(seed)) & 13'h1ffd;
      d = 16'($random(seed));
      xfer(2'h1, a, d, 2'h3, 1'b0, 16'h7, 16'h0);
      shadow[a] = d;
      d = 16'($random(seed));
      l = 2'h1 + 2'($random(seed) & 1);
      xfer(2'h1, a, d, l, 1'b0, 16'h7, 16'h0);
      shadow[a] = merge(shadow[a], d, l);
      fw = 1'($random(seed));
      xfer(2'h0, a, 16'h0, 2'h3, fw, fw ? 16'ha : 16'h6, shadow[a]);
    end
    fork
      xfer(2'h0, a, 16'h0, 2'h3, 1'b0, 16'h8, shadow[a]);
      begin
        busy_n = 1'b0;
        repeat (4) @(negedge clk);
        busy_n = 1'b1;
      end
    join
    check("busy seen", 16'(busy_seen), 16'h1);
    for (int i = 0; i < 2; i++) begin
      a = 13'($random(seed));
      xfer(2'h3, a, {15'($random(seed)), i[0]}, 2'h3, 1'b0, 16'h7, 16'h0);
      xfer(2'h2, a ^ 13'h1ff8, 16'h0, 2'h3, 1'b0, 16'h6, 16'(i));
    end
    xfer(2'h1, MBOX_LEFT_ADDR, 16'h00a5, 2'h3, 1'b0, 16'h7, 16'h0);
    xfer(2'h1, MBOX_RIGHT_ADDR, 16'h5a00, 2'h3, 1'b0, 16'h7, 16'h0);
    peer_mbox_wr = 1'b1;
    @(negedge clk);
    peer_mbox_wr = 1'b0;
    repeat (2) @(negedge clk);
    check("alert set", 16'(alert), 16'h1);
    xfer(2'h0, MBOX_RIGHT_ADDR, 16'h0, 2'h3, 1'b0, 16'h6, 16'h5a00);
    check("alert kept", 16'(alert), 16'h1);
    xfer(2'h0, MBOX_LEFT_ADDR, 16'h0, 2'h3, 1'b0, 16'h6, 16'h00a5);
    check("alert cleared", 16'(alert), 16'h0);
    tally_and_finish();
  end
endmodule // tb
